/* core/tmr_ff_pkg.sv */
// Constants, register map and types for the output flip-flop source selection block
package tmr_ff_pkg;
    localparam int REG_MSB = 15;
    localparam int NUM_IO = 5;
    localparam int NUM_ST = 5;
    localparam int NUM_BUS = 4;
    localparam int FF_LO = 6;
    localparam int FF_HI = 15;
    localparam int ST_BASE = 6;

    // Byte addresses on the register bus
    localparam logic [31:0] ADDR_SRC_SEL_LOW = 32'h0080_0220;
    localparam logic [31:0] ADDR_EVBUS_SEL = 32'h0080_0230;
    localparam logic [31:0] ADDR_FF_STATE = 32'h0080_0234;

    localparam logic [15:0] RST_SRC_SEL_LOW = 16'h0000;
    localparam logic [15:0] SRC_SEL_LOW_MASK = 16'h1FFF;
    localparam logic [3:0] RST_EVBUS_SEL = 4'h0;
    localparam logic [3:0] STRB_HALF = 4'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Bit position 0 is the register MSB
    function automatic int reg_bit(input int pos);
        return REG_MSB - pos;
    endfunction

    localparam int POS_SRC_SEL_A = 3;
    localparam int POS_SRC_SEL_B = 4;
    localparam int POS_SRC_SEL_C = 5;
    localparam int POS_SRC_SEL_D = 6;
    localparam int POS_SRC_SEL_E = 7;
    localparam int POS_SRC_SEL_F = 8;
    localparam int POS_FF9_SRC_SEL = 10;
    localparam int POS_FF8_SRC_SEL = 12;
    localparam int POS_FF7_SRC_SEL = 14;
    localparam int POS_FF6_SRC_SEL = 15;

    typedef enum logic [2:0] {
        MODE_SINGLE = 3'h0,
        MODE_DELAYED = 3'h1,
        MODE_CONT = 3'h2,
        MODE_PWM = 3'h3,
        MODE_MEAS_CLR = 3'h4,
        MODE_MEAS_FREE = 3'h5,
        MODE_NOISE = 3'h6,
        MODE_STOP = 3'h7
    } tmr_mode_t;

    typedef struct packed {
        logic cnt_en;
        logic udf;
        tmr_mode_t mode;
    } tmr_evt_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'h0,
        WR_RESP = 2'h1
    } wr_state_t;
endpackage

/* core/timer_output_ff_source_select.sv */
// Output flip-flop source selection, event buses and AXI4-Lite register slave
// Overview of operation
// - Every timer output owns a dedicated output flip-flop in this block.
// - Single-shot, continuous and PWM modes signal on counter enable and on underflow.
// - Delayed single-shot mode signals only on underflow, never on enable.
// - Measure-clear, measure-free-run and noise input modes signal only on underflow.
// - 16-bit and 32-bit measurement timers have no path to any flip-flop.
// - Flip-flop signals occur at instants different from event bus drive instants.
// - Flip-flop 15: bit 3 zero picks io timer 4, one picks bus 0.
// - Flip-flop 14: bit 4 zero picks io timer 3, one picks bus 0.
// - Flip-flop 13: bit 5 zero picks io timer 2, one picks bus 3.
// - Flip-flop 12: bit 6 zero picks io timer 1, one picks bus 2.
// - Flip-flop 11: bit 7 zero picks io timer 0, one picks bus 1.
// - Flip-flop 10, bits 8-9: 0X simple timer 10, 10 bus 0, 11 bus 1.
// - Flip-flop 9, bits 10-11: 0X simple timer 9, 10 bus 0, 11 bus 1.
// - Flip-flop 8, bits 12-13: 00 timer 8, 01 bus 0, 10 bus 1, 11 bus 2.
// - Flip-flop 7: bit 14 zero picks simple timer 7, one picks bus 0.
// - Flip-flop 6: bit 15 zero picks simple timer 6, one picks bus 1.
// - Each event bus carries the underflow of a selectable simple or io timer.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module timer_output_ff_source_select (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire tmr_ff_pkg::tmr_evt_t [tmr_ff_pkg::NUM_IO-1:0] io_tmr,
    input wire tmr_ff_pkg::tmr_evt_t [tmr_ff_pkg::NUM_ST-1:0] st_tmr,
    output logic [tmr_ff_pkg::NUM_BUS-1:0] out_evbus,
    output logic [tmr_ff_pkg::FF_HI:tmr_ff_pkg::FF_LO] ff_out
);
    // Mode decides whether counter enable, underflow or both reach the flip-flop
    function automatic logic ff_fire(input tmr_ff_pkg::tmr_evt_t t);
        case (t.mode)
            tmr_ff_pkg::MODE_SINGLE, tmr_ff_pkg::MODE_CONT, tmr_ff_pkg::MODE_PWM:
                ff_fire = t.cnt_en | t.udf;
            tmr_ff_pkg::MODE_DELAYED:
                ff_fire = t.udf;
            tmr_ff_pkg::MODE_MEAS_CLR, tmr_ff_pkg::MODE_MEAS_FREE, tmr_ff_pkg::MODE_NOISE:
                ff_fire = t.udf;
            default:
                ff_fire = 1'b0;
        endcase
    endfunction

    function automatic logic sel1(input logic s, input logic tmr, input logic bus);
        sel1 = s ? bus : tmr;
    endfunction

    // Code 0X keeps the timer, 10 and 11 pick one of two buses
    function automatic logic sel2(input logic [1:0] s, input logic tmr, input logic bus_a, input logic bus_b);
        case (s)
            2'h2: sel2 = bus_a;
            2'h3: sel2 = bus_b;
            default: sel2 = tmr;
        endcase
    endfunction

    localparam int BA = tmr_ff_pkg::reg_bit(tmr_ff_pkg::POS_SRC_SEL_A);
    localparam int BB = tmr_ff_pkg::reg_bit(tmr_ff_pkg::POS_SRC_SEL_B);
    localparam int BC = tmr_ff_pkg::reg_bit(tmr_ff_pkg::POS_SRC_SEL_C);
    localparam int BD = tmr_ff_pkg::reg_bit(tmr_ff_pkg::POS_SRC_SEL_D);
    localparam int BE = tmr_ff_pkg::reg_bit(tmr_ff_pkg::POS_SRC_SEL_E);
    localparam int BF = tmr_ff_pkg::reg_bit(tmr_ff_pkg::POS_SRC_SEL_F);
    localparam int B9 = tmr_ff_pkg::reg_bit(tmr_ff_pkg::POS_FF9_SRC_SEL);
    localparam int B8 = tmr_ff_pkg::reg_bit(tmr_ff_pkg::POS_FF8_SRC_SEL);
    localparam int B7 = tmr_ff_pkg::reg_bit(tmr_ff_pkg::POS_FF7_SRC_SEL);
    localparam int B6 = tmr_ff_pkg::reg_bit(tmr_ff_pkg::POS_FF6_SRC_SEL);

    logic [15:0] src_sel_low_ff, nxt_src_sel_low;
    logic [tmr_ff_pkg::NUM_BUS-1:0] evbus_sel_ff, nxt_evbus_sel;
    logic [tmr_ff_pkg::NUM_BUS-1:0] evbus_ff, nxt_evbus;
    logic [tmr_ff_pkg::NUM_IO-1:0] io_fire_ff, nxt_io_fire;
    logic [tmr_ff_pkg::NUM_ST-1:0] st_fire_ff, nxt_st_fire;
    logic [tmr_ff_pkg::FF_HI:tmr_ff_pkg::FF_LO] ff_ff, nxt_ff, ff_evt;

    // Named field views of the source-select register
    logic src_sel_a, src_sel_b, src_sel_c, src_sel_d, src_sel_e;
    logic [1:0] src_sel_f, ff9_src_sel, ff8_src_sel;
    logic ff7_src_sel, ff6_src_sel;
    assign src_sel_a = src_sel_low_ff[BA];
    assign src_sel_b = src_sel_low_ff[BB];
    assign src_sel_c = src_sel_low_ff[BC];
    assign src_sel_d = src_sel_low_ff[BD];
    assign src_sel_e = src_sel_low_ff[BE];
    assign src_sel_f = {src_sel_low_ff[BF], src_sel_low_ff[BF-1]};
    assign ff9_src_sel = {src_sel_low_ff[B9], src_sel_low_ff[B9-1]};
    assign ff8_src_sel = {src_sel_low_ff[B8], src_sel_low_ff[B8-1]};
    assign ff7_src_sel = src_sel_low_ff[B7];
    assign ff6_src_sel = src_sel_low_ff[B6];

    // Only channel timers have inputs here; measurement timers have no port at all
    genvar gi;
    generate
        for (gi = 0; gi < tmr_ff_pkg::NUM_IO; gi++) begin : g_io
            assign nxt_io_fire[gi] = ff_fire(io_tmr[gi]);
        end
        for (gi = 0; gi < tmr_ff_pkg::NUM_ST; gi++) begin : g_st
            assign nxt_st_fire[gi] = ff_fire(st_tmr[gi]);
        end
        for (gi = 0; gi < tmr_ff_pkg::NUM_BUS; gi++) begin : g_bus
            assign nxt_evbus[gi] = evbus_sel_ff[gi] ? io_tmr[gi].udf : st_tmr[gi].udf;
        end
    endgenerate

    // Bus is driven one cycle after the underflow, the flip-flop toggles one cycle later still
    always_comb begin
        ff_evt[15] = sel1(src_sel_a, io_fire_ff[4], evbus_ff[0]);
        ff_evt[14] = sel1(src_sel_b, io_fire_ff[3], evbus_ff[0]);
        ff_evt[13] = sel1(src_sel_c, io_fire_ff[2], evbus_ff[3]);
        ff_evt[12] = sel1(src_sel_d, io_fire_ff[1], evbus_ff[2]);
        ff_evt[11] = sel1(src_sel_e, io_fire_ff[0], evbus_ff[1]);
        ff_evt[10] = sel2(src_sel_f, st_fire_ff[10-tmr_ff_pkg::ST_BASE], evbus_ff[0], evbus_ff[1]);
        ff_evt[9] = sel2(ff9_src_sel, st_fire_ff[9-tmr_ff_pkg::ST_BASE], evbus_ff[0], evbus_ff[1]);
        case (ff8_src_sel)
            2'h1: ff_evt[8] = evbus_ff[0];
            2'h2: ff_evt[8] = evbus_ff[1];
            2'h3: ff_evt[8] = evbus_ff[2];
            default: ff_evt[8] = st_fire_ff[8-tmr_ff_pkg::ST_BASE];
        endcase
        ff_evt[7] = sel1(ff7_src_sel, st_fire_ff[7-tmr_ff_pkg::ST_BASE], evbus_ff[0]);
        ff_evt[6] = sel1(ff6_src_sel, st_fire_ff[6-tmr_ff_pkg::ST_BASE], evbus_ff[1]);
        nxt_ff = ff_ff ^ ff_evt;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            io_fire_ff <= '0;
            st_fire_ff <= '0;
            evbus_ff <= '0;
            ff_ff <= '0;
        end else begin
            io_fire_ff <= nxt_io_fire;
            st_fire_ff <= nxt_st_fire;
            evbus_ff <= nxt_evbus;
            ff_ff <= nxt_ff;
        end
    end

    assign out_evbus = evbus_ff;
    assign ff_out = ff_ff;

    // Register slave, write side
    tmr_ff_pkg::wr_state_t wr_state_ff, nxt_wr_state;
    logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
    logic awready_ff, nxt_awready, wready_ff, nxt_wready, bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic [31:0] awaddr_ff, nxt_awaddr, wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic aw_hs, w_hs;
    logic [31:0] wr_addr, wr_data;
    logic [3:0] wr_strb;

    assign aw_hs = s_axi_awvalid & awready_ff;
    assign w_hs = s_axi_wvalid & wready_ff;

    always_comb begin
        nxt_wr_state = wr_state_ff;
        nxt_aw_got = aw_got_ff;
        nxt_w_got = w_got_ff;
        nxt_awready = awready_ff;
        nxt_wready = wready_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_src_sel_low = src_sel_low_ff;
        nxt_evbus_sel = evbus_sel_ff;
        wr_addr = aw_got_ff ? awaddr_ff : s_axi_awaddr;
        wr_data = w_got_ff ? wdata_ff : s_axi_wdata;
        wr_strb = w_got_ff ? wstrb_ff : s_axi_wstrb;
        case (wr_state_ff)
            tmr_ff_pkg::WR_IDLE: begin
                if (aw_hs) begin
                    nxt_aw_got = 1'b1;
                    nxt_awaddr = s_axi_awaddr;
                    nxt_awready = 1'b0;
                end
                if (w_hs) begin
                    nxt_w_got = 1'b1;
                    nxt_wdata = s_axi_wdata;
                    nxt_wstrb = s_axi_wstrb;
                    nxt_wready = 1'b0;
                end
                if ((aw_got_ff | aw_hs) & (w_got_ff | w_hs)) begin
                    nxt_wr_state = tmr_ff_pkg::WR_RESP;
                    nxt_bvalid = 1'b1;
                    nxt_awready = 1'b0;
                    nxt_wready = 1'b0;
                    nxt_bresp = tmr_ff_pkg::RESP_OKAY;
                    case (wr_addr)
                        tmr_ff_pkg::ADDR_SRC_SEL_LOW: begin
                            // Only a strobe of exactly the two low lanes is taken; any other strobe, partial or full, is refused whole
                            if (wr_strb == tmr_ff_pkg::STRB_HALF) begin
                                nxt_src_sel_low = wr_data[15:0] & tmr_ff_pkg::SRC_SEL_LOW_MASK;
                            end else begin
                                nxt_bresp = tmr_ff_pkg::RESP_SLVERR;
                            end
                        end
                        tmr_ff_pkg::ADDR_EVBUS_SEL: begin
                            if (wr_strb[0]) begin
                                nxt_evbus_sel = wr_data[tmr_ff_pkg::NUM_BUS-1:0];
                            end
                        end
                        tmr_ff_pkg::ADDR_FF_STATE: begin
                            nxt_bresp = tmr_ff_pkg::RESP_OKAY;
                        end
                        default: begin
                            nxt_bresp = tmr_ff_pkg::RESP_DECERR;
                        end
                    endcase
                end
            end
            tmr_ff_pkg::WR_RESP: begin
                if (s_axi_bready) begin
                    nxt_wr_state = tmr_ff_pkg::WR_IDLE;
                    nxt_bvalid = 1'b0;
                    nxt_aw_got = 1'b0;
                    nxt_w_got = 1'b0;
                    nxt_awready = 1'b1;
                    nxt_wready = 1'b1;
                end
            end
            default: begin
                nxt_wr_state = tmr_ff_pkg::WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_state_ff <= tmr_ff_pkg::WR_IDLE;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= tmr_ff_pkg::RESP_OKAY;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            src_sel_low_ff <= tmr_ff_pkg::RST_SRC_SEL_LOW;
            evbus_sel_ff <= tmr_ff_pkg::RST_EVBUS_SEL;
        end else begin
            wr_state_ff <= nxt_wr_state;
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            src_sel_low_ff <= nxt_src_sel_low;
            evbus_sel_ff <= nxt_evbus_sel;
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // Register slave, read side
    logic arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;

    always_comb begin
        nxt_arready = arready_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_axi_arvalid & arready_ff) begin
            nxt_arready = 1'b0;
            nxt_rvalid = 1'b1;
            nxt_rresp = tmr_ff_pkg::RESP_OKAY;
            case (s_axi_araddr)
                tmr_ff_pkg::ADDR_SRC_SEL_LOW: nxt_rdata = {16'h0000, src_sel_low_ff};
                tmr_ff_pkg::ADDR_EVBUS_SEL: nxt_rdata = {28'h0000000, evbus_sel_ff};
                tmr_ff_pkg::ADDR_FF_STATE: nxt_rdata = {16'h0000, ff_ff, 2'h0, evbus_ff};
                default: begin
                    nxt_rdata = 32'h00000000;
                    nxt_rresp = tmr_ff_pkg::RESP_DECERR;
                end
            endcase
        end else if (rvalid_ff & s_axi_rready) begin
            nxt_rvalid = 1'b0;
            nxt_arready = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= tmr_ff_pkg::RESP_OKAY;
        end else begin
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
endmodule
`default_nettype wire

/* tb/ff_sel_checker.sv */
// Concurrent checks on the ports of the output flip-flop source selection block
`timescale 1ns/1ps
`default_nettype none
module ff_sel_checker (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire tmr_ff_pkg::tmr_evt_t [tmr_ff_pkg::NUM_IO-1:0] io_tmr,
    input wire tmr_ff_pkg::tmr_evt_t [tmr_ff_pkg::NUM_ST-1:0] st_tmr,
    input wire logic [tmr_ff_pkg::NUM_BUS-1:0] out_evbus,
    input wire logic [tmr_ff_pkg::FF_HI:tmr_ff_pkg::FF_LO] ff_out
);
    logic [12:0] sel_ff, nxt_sel;
    logic [4:0] fio, fst, uio, ust;
    function automatic logic fires(input tmr_ff_pkg::tmr_evt_t t);
        return (t.cnt_en && t.mode inside {3'h0, 3'h2, 3'h3}) || (t.udf && t.mode != 3'h7);
    endfunction
    // Shadow of the select register; only tracks address and data taken together
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            fio[i] = fires(io_tmr[i]);
            fst[i] = fires(st_tmr[i]);
            uio[i] = io_tmr[i].udf;
            ust[i] = st_tmr[i].udf;
        end
        nxt_sel = sel_ff;
        if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb == 4'h3
            && s_axi_awaddr == tmr_ff_pkg::ADDR_SRC_SEL_LOW) begin
            nxt_sel = s_axi_wdata[12:0];
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_ff <= 13'h0;
        end else begin
            sel_ff <= nxt_sel;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence aw_w_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence ar_taken; s_axi_arvalid && s_axi_arready; endsequence
    sequence r_shown; s_axi_rvalid && !s_axi_arready; endsequence
    AST_EVBUS_SRC: assert property ((out_evbus & ~$past(uio[3:0] | ust[3:0])) == 4'h0)
        else $error("event bus pulse without underflow");
    AST_EVBUS_BOTH: assert property (($past(uio[3:0] & ust[3:0]) & ~out_evbus) == 4'h0)
        else $error("event bus missed underflow");
    // The toggle is decided one edge earlier, so the select in force then is the one that counts
    AST_SRC_SEL_A: assert property ((ff_out[15] ^ $past(ff_out[15])) == ($past(sel_ff[12]) ? $past(out_evbus[0]) : $past(fio[4], 2)))
        else $error("flip-flop 15 toggle wrong");
    AST_SRC_SEL_E: assert property ((ff_out[11] ^ $past(ff_out[11])) == ($past(sel_ff[8]) ? $past(out_evbus[1]) : $past(fio[0], 2)))
        else $error("flip-flop 11 toggle wrong");
    AST_FF8: assert property ((ff_out[8] ^ $past(ff_out[8])) ==
        ($past(sel_ff[3:2]) == 2'h0 ? $past(fst[2], 2) : $past(out_evbus[sel_ff[3:2] - 2'h1])))
        else $error("flip-flop 8 toggle wrong");
    AST_FF6: assert property ((ff_out[6] ^ $past(ff_out[6])) == ($past(sel_ff[0]) ? $past(out_evbus[1]) : $past(fst[0], 2)))
        else $error("flip-flop 6 toggle wrong");
    AST_FF_QUIET: assert property (!$stable(ff_out) |-> $past(|(fio | fst), 2) || $past(|out_evbus))
        else $error("flip-flop changed without a source event");
    AST_B_ANSWER: assert property (aw_w_taken |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write response late");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write response not retired");
    AST_R_ANSWER: assert property (ar_taken |=> r_shown)
        else $error("read response late");
endmodule
bind timer_output_ff_source_select ff_sel_checker chk (.mclk(mclk), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .io_tmr(io_tmr), .st_tmr(st_tmr),
    .out_evbus(out_evbus), .ff_out(ff_out));
`default_nettype wire

/* tb/timer_chan_model.sv */
// Timer channels: register a command; enable and underflow pulses pass only while go is high
`timescale 1ns/1ps
`default_nettype none
module timer_chan_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic go,
    input wire tmr_ff_pkg::tmr_evt_t [4:0] cmd_io,
    input wire tmr_ff_pkg::tmr_evt_t [4:0] cmd_st,
    output logic [24:0] io_tmr,
    output logic [24:0] st_tmr
);
    tmr_ff_pkg::tmr_evt_t [4:0] io_ff, st_ff, nxt_io_ff, nxt_st_ff;
    // Mode stays a level between commands; enable and underflow pass only while go is high
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            nxt_io_ff[i] = cmd_io[i] & {go, go, 3'h7};
            nxt_st_ff[i] = cmd_st[i] & {go, go, 3'h7};
        end
    end
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            io_ff <= '0;
            st_ff <= '0;
        end else begin
            io_ff <= nxt_io_ff;
            st_ff <= nxt_st_ff;
        end
    end
    assign io_tmr = io_ff;
    assign st_tmr = st_ff;
endmodule
`default_nettype wire

/* tb/timer_output_ff_source_select_bench.sv */
// Self-checking bench for the output flip-flop source selection block
`timescale 1ns/1ps
`default_nettype none
module timer_output_ff_source_select_bench;
    localparam logic [31:0] A_SEL = tmr_ff_pkg::ADDR_SRC_SEL_LOW;
    localparam logic [31:0] A_EVB = tmr_ff_pkg::ADDR_EVBUS_SEL;
    localparam logic [31:0] A_ST = tmr_ff_pkg::ADDR_FF_STATE;
    localparam logic [1:0] OK = tmr_ff_pkg::RESP_OKAY;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0, out_evbus, evs = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, go = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    tmr_ff_pkg::tmr_evt_t [4:0] cmd_io = '0, cmd_st = '0;
    tmr_ff_pkg::tmr_evt_t [4:0] io_tmr, st_tmr;
    logic [15:6] ff_out, ff_exp = 10'h0;
    logic [12:0] sel = 13'h0;
    logic [33:0] q_r[$], e_r;
    logic [1:0] q_b[$];
    int n_errors = 0, n_compared = 0;

    always #2 mclk = ~mclk;

    timer_output_ff_source_select uut (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .io_tmr(io_tmr), .st_tmr(st_tmr), .out_evbus(out_evbus), .ff_out(ff_out));
    timer_chan_model chan (.mclk(mclk), .sys_rst(sys_rst), .go(go), .cmd_io(cmd_io), .cmd_st(cmd_st),
        .io_tmr(io_tmr), .st_tmr(st_tmr));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        q_b.push_back(r);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // No cycle count is assumed; only the watchdog ends a hung wait
        forever begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        q_r.push_back({r, d});
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
    endtask

    function automatic logic fire(input tmr_ff_pkg::tmr_evt_t t);
        return (t.cnt_en && t.mode inside {3'h0, 3'h2, 3'h3}) || (t.udf && t.mode != 3'h7);
    endfunction

    // One cycle of random pulses from every timer; toggles accumulate in ff_exp
    task automatic step();
        tmr_ff_pkg::tmr_evt_t [4:0] ci, cs;
        logic [4:0] fi, fs;
        logic [3:0] b;
        ci = 25'($urandom);
        cs = 25'($urandom);
        for (int i = 0; i < 5; i++) begin
            fi[i] = fire(ci[i]);
            fs[i] = fire(cs[i]);
            if (i < 4) b[i] = evs[i] ? ci[i].udf : cs[i].udf;
        end
        ff_exp[15] ^= sel[12] ? b[0] : fi[4];
        ff_exp[14] ^= sel[11] ? b[0] : fi[3];
        ff_exp[13] ^= sel[10] ? b[3] : fi[2];
        ff_exp[12] ^= sel[9] ? b[2] : fi[1];
        ff_exp[11] ^= sel[8] ? b[1] : fi[0];
        ff_exp[10] ^= sel[7] ? b[sel[6]] : fs[4];
        ff_exp[9] ^= sel[5] ? b[sel[4]] : fs[3];
        ff_exp[8] ^= (sel[3:2] == 2'h0) ? fs[2] : b[sel[3:2] - 2'h1];
        ff_exp[7] ^= sel[1] ? b[0] : fs[1];
        ff_exp[6] ^= sel[0] ? b[1] : fs[0];
        @(posedge mclk);
        go <= 1'b1;
        cmd_io <= ci;
        cmd_st <= cs;
    endtask

    always @(posedge mclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            e_r = q_r.pop_front();
            check("rdata", s_axi_rdata, e_r[31:0]);
            check("rresp", {30'h0, s_axi_rresp}, {30'h0, e_r[33:32]});
        end
        if (s_axi_bvalid && s_axi_bready) check("bresp", {30'h0, s_axi_bresp}, {30'h0, q_b.pop_front()});
    end

    initial begin
        #200000;
        n_errors++;
        final_report();
    end

    initial begin
        void'($urandom(32'hF10C992E));
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(A_SEL, 32'h0, OK);
        rd(A_ST, 32'h0, OK);
        rd(32'h0080_0238, 32'h0, tmr_ff_pkg::RESP_DECERR);
        wr(32'h0080_0238, 32'h1, 4'hF, tmr_ff_pkg::RESP_DECERR);
        wr(A_SEL, 32'hFFFF_FFFF, 4'hF, tmr_ff_pkg::RESP_SLVERR);
        wr(A_SEL, 32'hFFFF_FFFF, 4'h1, tmr_ff_pkg::RESP_SLVERR);
        wr(A_ST, 32'hFFFF_FFFF, 4'h3, OK);
        rd(A_SEL, 32'h0, OK);
        rd(A_ST, 32'h0, OK);
        // Random selections cover every code of every selector over the loop
        for (int n = 0; n < 40; n++) begin
            sel = 13'($urandom);
            evs = 4'($urandom);
            wr(A_SEL, {19'($urandom), sel}, 4'h3, OK);
            wr(A_EVB, {28'($urandom), evs}, 4'h1, OK);
            rd(A_SEL, {19'h0, sel}, OK);
            rd(A_EVB, {28'h0, evs}, OK);
            repeat (3) step();
            @(posedge mclk);
            go <= 1'b0;
            repeat (4) @(posedge mclk);
            rd(A_ST, {16'h0, ff_exp, 6'h0}, OK);
        end
        final_report();
    end
endmodule
`default_nettype wire
